// ==== rtl/rgpg_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by rgpg_pkg.sv and rgpg_regs.sv by bare name
// Notes:   definitions only
`ifndef RGPG_DEFS_SVH
`define RGPG_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define RGPG_OFF_MODE 8'h9C  // stepdown_mode_and_override
`define RGPG_OFF_DLY 8'h9D  // power_good_delay_two

// ****************************************************************
// reset values
// ****************************************************************
`define RGPG_RST_MODE 8'h07
`define RGPG_RST_DLY 8'h21

// ****************************************************************
// field positions
// ****************************************************************
`define RGPG_MODE_LSB 3  // conv1..conv3 mode select at 3..5
`define RGPG_OVR_LSB 0  // conv1..conv3 off override at 0..2
`define RGPG_DLY_TWO_LSB 5  // out_two_good_delay 7:5
`define RGPG_DLY_FOUR_LSB 2  // out_four_good_delay 4:2
`define RGPG_DLY_ONE_LSB 0  // out_one_good_delay 1:0

// ****************************************************************
// timing
// ****************************************************************
`define RGPG_CLK_NS 8  // clock period in ns
`define RGPG_MS_NS 1000000  // one millisecond in ns
`define RGPG_DLY0_MS 7'h00
`define RGPG_DLY1_MS 7'h05
`define RGPG_DLY2_MS 7'h0A
`define RGPG_DLY3_MS 7'h0F
`define RGPG_DLY4_MS 7'h14
`define RGPG_DLY5_MS 7'h32
`define RGPG_DLY6_MS 7'h4B
`define RGPG_DLY7_MS 7'h64

`endif

// ==== rtl/rgpg_pkg.sv ====
// Purpose: types shared by the mode and power-good delay block
// Assumes: constants come from rgpg_defs.svh
// Notes:   one-hot delay state per general output
`include "rgpg_defs.svh"
package rgpg_pkg;
    // ****************************************************************
    // per-output power-good state
    // ****************************************************************
    typedef enum logic [2:0] {
        RGPG_WAIT = 3'h1,  // some grouped rail not in regulation
        RGPG_COUNT = 3'h2,  // all rails ok, delay running
        RGPG_GOOD = 3'h4  // delay elapsed, power good asserted
    } rgpg_pg_state_t;

    typedef logic [7:0] rgpg_byte_t;  // register width
    typedef logic [6:0] rgpg_ms_t;  // delay in ms, up to 100
    typedef logic [16:0] rgpg_pre_t;  // cycles within one ms
endpackage

// ==== rtl/rgpg_regs.sv ====
// Purpose: converter mode/override register and power-good delays
// Assumes: register port is driven by the serial interface logic on
//          i_clk; rail regulation status comes from analogue pins
// Notes:   index 0 = general output one, 1 = two, 2 = four
// Function
// [RULE1] three mode bits, 0 auto, 1 forced PWM
// [RULE2] override bit 0 turns converter off always
// [RULE3] override beats forced-on enable
// [RULE4] output two delay code in bits 7:5
// [RULE5] output four delay code in bits 4:2
// [RULE6] output one two-bit delay in 1:0
// [RULE7] delay starts when all grouped rails regulate
// [RULE8] delays may deviate ten percent
// [RULE9] delay applies only in power-good configuration
// [RULE10] bits 7:6 spare storage, reset zero
// [RULE11] rail loss drops power good, restarts delay
// [RULE12] delay edits apply to next interval
`timescale 1ns/1ps
`default_nettype none
`include "rgpg_defs.svh"
module rgpg_regs #(
    parameter int P_CYC_PER_MS = `RGPG_MS_NS / `RGPG_CLK_NS  // cycles/ms
) (
    input wire logic i_clk,  // 125 MHz clock
    input wire logic i_rst,  // async reset, active high
    input wire logic i_ce,  // clock enable, freezes all state
    input wire rgpg_pkg::rgpg_byte_t i_addr,  // register offset
    input wire logic i_wr_en,  // write strobe, one cycle
    input wire rgpg_pkg::rgpg_byte_t i_wr_data,  // write data
    input wire logic i_rd_en,  // read strobe, one cycle
    output logic [7:0] o_rd_data,  // read data, one cycle later
    input wire logic [2:0] i_rail_ctrl_on,  // enables from control pins
    input wire logic [2:0] i_conv_forced_on,  // serial forced-on enables
    output logic [2:0] o_conv_enable,  // converter 1..3 enables
    output logic [2:0] o_conv_mode,  // converter 1..3 forced PWM
    input wire logic [2:0] i_rails_in_reg,  // per output, async pins
    input wire logic [2:0] i_out_is_pg,  // output configured as power good
    output logic [2:0] o_power_good  // general outputs one, two, four
);
    import rgpg_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************
    // delay code to milliseconds; shared by all three outputs
    function automatic rgpg_ms_t code_ms(input logic [2:0] code);
        rgpg_ms_t ms;
        case (code)  // [RULE4] [RULE5] [RULE6]
            3'h0: ms = `RGPG_DLY0_MS;
            3'h1: ms = `RGPG_DLY1_MS;
            3'h2: ms = `RGPG_DLY2_MS;
            3'h3: ms = `RGPG_DLY3_MS;
            3'h4: ms = `RGPG_DLY4_MS;
            3'h5: ms = `RGPG_DLY5_MS;
            3'h6: ms = `RGPG_DLY6_MS;
            default: ms = `RGPG_DLY7_MS;
        endcase
        return ms;
    endfunction

    localparam rgpg_pre_t PRE_LAST = rgpg_pre_t'(P_CYC_PER_MS - 1);

    // ****************************************************************
    // register file
    // ****************************************************************
    rgpg_byte_t mode_reg;  // stepdown_mode_and_override
    rgpg_byte_t dly_reg;  // power_good_delay_two
    rgpg_byte_t next_mode_reg;
    rgpg_byte_t next_dly_reg;
    logic [7:0] next_rd_data;
    logic [2:0] next_conv_enable;
    logic [2:0] next_conv_mode;

    // writes, reads and converter control; unmapped offsets read 00
    always_comb begin
        next_mode_reg = mode_reg;
        next_dly_reg = dly_reg;
        next_rd_data = o_rd_data;
        if (i_wr_en && i_addr == `RGPG_OFF_MODE) begin
            next_mode_reg = i_wr_data;  // [RULE1] [RULE2] [RULE10]
        end
        if (i_wr_en && i_addr == `RGPG_OFF_DLY) begin
            next_dly_reg = i_wr_data;  // [RULE4] [RULE5] [RULE6]
        end
        if (i_rd_en) begin
            case (i_addr)
                `RGPG_OFF_MODE: next_rd_data = mode_reg;
                `RGPG_OFF_DLY: next_rd_data = dly_reg;
                default: next_rd_data = 8'h00;
            endcase
        end
        next_conv_mode = mode_reg[`RGPG_MODE_LSB +: 3];  // [RULE1]
        // override low forces off, whatever pins or forced-on ask
        next_conv_enable = (i_rail_ctrl_on | i_conv_forced_on)
                         & mode_reg[`RGPG_OVR_LSB +: 3];  // [RULE2] [RULE3]
    end

    // register update, frozen while i_ce is low
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg <= `RGPG_RST_MODE;
            dly_reg <= `RGPG_RST_DLY;
            o_rd_data <= 8'h00;
            o_conv_enable <= 3'h0;
            o_conv_mode <= 3'h0;
        end else if (i_ce) begin
            mode_reg <= next_mode_reg;
            dly_reg <= next_dly_reg;
            o_rd_data <= next_rd_data;
            o_conv_enable <= next_conv_enable;
            o_conv_mode <= next_conv_mode;
        end
    end

    // ****************************************************************
    // rail status synchroniser
    // ****************************************************************
    logic [2:0] ok_meta;  // first stage, read only by ok_sync
    logic [2:0] ok_sync;  // rail groups in regulation, safe to use

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ok_meta <= 3'h0;
            ok_sync <= 3'h0;
        end else if (i_ce) begin
            ok_meta <= i_rails_in_reg;
            ok_sync <= ok_meta;
        end
    end

    // ****************************************************************
    // power-good delay engines
    // ****************************************************************
    rgpg_pg_state_t st [3];  // state per output
    rgpg_pg_state_t next_st [3];
    rgpg_pre_t pre [3];  // cycle count inside current ms
    rgpg_pre_t next_pre [3];
    rgpg_ms_t ms_cnt [3];  // whole ms elapsed
    rgpg_ms_t next_ms_cnt [3];
    rgpg_ms_t tgt [3];  // target latched at start of interval
    rgpg_ms_t next_tgt [3];
    rgpg_ms_t code_now [3];  // delay currently programmed
    logic [2:0] next_power_good;

    // counters are exact; the allowed ten percent spread is left to
    // the clock tolerance rather than trimmed here  [RULE8]
    always_comb begin
        code_now[0] = code_ms({1'b0, dly_reg[`RGPG_DLY_ONE_LSB +: 2]});
        code_now[1] = code_ms(dly_reg[`RGPG_DLY_TWO_LSB +: 3]);
        code_now[2] = code_ms(dly_reg[`RGPG_DLY_FOUR_LSB +: 3]);
        for (int i = 0; i < 3; i++) begin
            next_st[i] = st[i];
            next_pre[i] = pre[i];
            next_ms_cnt[i] = ms_cnt[i];
            next_tgt[i] = tgt[i];
            case (st[i])
                RGPG_WAIT: begin
                    next_pre[i] = '0;
                    next_ms_cnt[i] = '0;
                    if (ok_sync[i]) begin  // [RULE7]
                        next_tgt[i] = code_now[i];  // [RULE12]
                        next_st[i] = (code_now[i] == 7'h00) ?
                                     RGPG_GOOD : RGPG_COUNT;
                    end
                end
                RGPG_COUNT: begin
                    if (!ok_sync[i]) begin
                        next_st[i] = RGPG_WAIT;  // [RULE11]
                    end else if (pre[i] == PRE_LAST) begin
                        next_pre[i] = '0;
                        next_ms_cnt[i] = ms_cnt[i] + 7'h01;
                        if (ms_cnt[i] + 7'h01 == tgt[i]) begin
                            next_st[i] = RGPG_GOOD;  // [RULE7]
                        end
                    end else begin
                        next_pre[i] = pre[i] + 17'h00001;
                    end
                end
                RGPG_GOOD: begin
                    if (!ok_sync[i]) begin
                        next_st[i] = RGPG_WAIT;  // [RULE11]
                    end
                end
                default: next_st[i] = RGPG_WAIT;
            endcase
            // level-shifter or general use bypasses the delay
            next_power_good[i] = i_out_is_pg[i] ?
                (next_st[i] == RGPG_GOOD) : ok_sync[i];  // [RULE9]
        end
    end

    // delay engine registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 3; i++) begin
                st[i] <= RGPG_WAIT;
                pre[i] <= '0;
                ms_cnt[i] <= '0;
                tgt[i] <= '0;
            end
            o_power_good <= 3'h0;
        end else if (i_ce) begin
            for (int i = 0; i < 3; i++) begin
                st[i] <= next_st[i];
                pre[i] <= next_pre[i];
                ms_cnt[i] <= next_ms_cnt[i];
                tgt[i] <= next_tgt[i];
            end
            o_power_good <= next_power_good;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_mode_follows: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce) |-> o_conv_mode == $past(mode_reg[5:3])) // [RULE1]
        else $error("converter mode does not follow register");
    a_override_off: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce) && !$past(mode_reg[0]) |-> !o_conv_enable[0]) // [RULE3]
        else $error("converter one on despite override");
    a_forced_on: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce && mode_reg[1] && i_conv_forced_on[1])
        |-> o_conv_enable[1]) // [RULE2]
        else $error("forced-on converter two not enabled");
    a_mode_write: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce && i_wr_en && i_addr == `RGPG_OFF_MODE)
        |-> mode_reg == $past(i_wr_data)) // [RULE10]
        else $error("mode register write lost");
    a_delay_read: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce && i_rd_en && i_addr == `RGPG_OFF_DLY)
        |-> o_rd_data == $past(dly_reg)) // [RULE5]
        else $error("delay register read wrong");
    a_target_held: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(st[1] == RGPG_COUNT) && st[1] == RGPG_COUNT
        |-> tgt[1] == $past(tgt[1])) // [RULE12]
        else $error("delay target changed mid interval");
    a_start_target: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && st[1] == RGPG_WAIT && ok_sync[1]
        |=> tgt[1] == code_ms($past(dly_reg[7:5]))) // [RULE4]
        else $error("output two target not latched from code");
    a_pg_drop: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !ok_sync[2] |=> !o_power_good[2]) // [RULE11]
        else $error("power good held with rails out");
    a_count_bound: assert property (@(posedge i_clk) disable iff (i_rst)
        st[0] == RGPG_COUNT |-> ms_cnt[0] < tgt[0]
        && pre[0] <= PRE_LAST) // [RULE6]
        else $error("output one delay counter overran");
    a_pg_mode: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce && i_out_is_pg[0]) |-> o_power_good[0]
        == (st[0] == RGPG_GOOD)) // [RULE9]
        else $error("power good mismatch with delay state");
    a_zero_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && st[2] == RGPG_WAIT && ok_sync[2] && code_now[2] == 7'h00
        |=> st[2] == RGPG_GOOD) // [RULE7]
        else $error("zero delay did not assert at once");
endmodule // rgpg_regs
`default_nettype wire

// ==== sim/rgpg_tb.sv ====
// Purpose: self-checking bench for the mode/override and delay block
// Assumes: P_CYC_PER_MS shortened to 4, so one ms is four clocks
// Notes:   delay checks allow ten percent plus sync latency
`timescale 1ns/1ps
`default_nettype none
`include "rgpg_defs.svh"
module testbench;
    import rgpg_pkg::*;
    localparam int P_MS = 4;  // cycles per ms, keeps the run short
    int ms_tab [8] = '{0, 5, 10, 15, 20, 50, 75, 100};  // code to ms
    logic i_clk, i_rst, i_ce, i_wr_en, i_rd_en;
    rgpg_byte_t i_addr, i_wr_data;
    logic [7:0] o_rd_data, rd_v;
    logic [2:0] i_rail_ctrl_on, i_conv_forced_on, o_conv_enable;
    logic [2:0] o_conv_mode, i_rails_in_reg, i_out_is_pg, o_power_good;
    int error_cnt = 0;
    int check_count = 0;
    int n, m;
    // ****************************************************************
    // device under test
    // ****************************************************************
    rgpg_regs #(.P_CYC_PER_MS(P_MS)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
        .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
        .o_rd_data(o_rd_data), .i_rail_ctrl_on(i_rail_ctrl_on),
        .i_conv_forced_on(i_conv_forced_on), .o_conv_enable(o_conv_enable),
        .o_conv_mode(o_conv_mode), .i_rails_in_reg(i_rails_in_reg),
        .i_out_is_pg(i_out_is_pg), .o_power_good(o_power_good));
    // ****************************************************************
    // clock, compare and bus tasks
    // ****************************************************************
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;  // 125 MHz
    end
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        check_count++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1'b1;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd_en <= 1'b1;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1 chk8("rd_data", e, o_rd_data);
    endtask
    // outputs follow a write one edge after the register
    task automatic out_chk(input logic [2:0] en, input logic [2:0] md);
        repeat (2) @(posedge i_clk);
        #1 chk8("conv_enable", {5'h00, en}, {5'h00, o_conv_enable});
        chk8("conv_mode", {5'h00, md}, {5'h00, o_conv_mode});
    endtask
    // rails and power-good helpers; n counts edges until the change
    task automatic rail(input int idx, input logic v);
        @(posedge i_clk);
        if (v) i_rails_in_reg <= i_rails_in_reg | (3'b001 << idx);
        else i_rails_in_reg <= i_rails_in_reg & ~(3'b001 << idx);
    endtask
    task automatic wait_pg(input int idx, input logic v, output int c);
        c = 0;
        while (c < 600 && o_power_good[idx] !== v) begin
            @(posedge i_clk);
            c++;
            #1;
        end
    endtask
    // accept nominal +-10 %, plus up to four edges of sync latency
    task automatic rise_chk(input int idx, input int ms);
        rail(idx, 1'b1);
        wait_pg(idx, 1'b1, n);
        chk_rng("pg_delay", ms * P_MS * 9 / 10, ms * P_MS * 11 / 10 + 4,
                n);
        rail(idx, 1'b0);
        wait_pg(idx, 1'b0, m);
        chk_rng("pg_drop", 1, 4, m);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        rd_chk(`RGPG_OFF_MODE, 8'h07);
        rd_chk(`RGPG_OFF_DLY, 8'h21);
        chk8("pg_reset", 8'h00, {5'h00, o_power_good});
        rd_chk(8'h9E, 8'h00);  // unmapped offset reads zero
        $display("test reset done, errors %0d", error_cnt);
    endtask
    task automatic t_mode();
        @(posedge i_clk);
        i_rail_ctrl_on <= 3'b101;
        i_conv_forced_on <= 3'b010;
        wr(`RGPG_OFF_MODE, 8'hEA);
        out_chk(3'b010, 3'b101);
        rd_chk(`RGPG_OFF_MODE, 8'hEA);
        @(posedge i_clk);
        i_conv_forced_on <= 3'b111;
        wr(`RGPG_OFF_MODE, 8'h00);
        out_chk(3'b000, 3'b000);
        wr(`RGPG_OFF_MODE, 8'hDF);
        out_chk(3'b111, 3'b011);
        @(posedge i_clk);
        i_ce <= 1'b0;  // frozen: this write must be ignored
        wr(`RGPG_OFF_MODE, 8'h00);
        i_ce <= 1'b1;
        rd_chk(`RGPG_OFF_MODE, 8'hDF);
        wr(`RGPG_OFF_MODE, 8'h07);
        $display("test mode done, errors %0d", error_cnt);
    endtask
    task automatic t_delay();
        for (int c = 0; c < 8; c++) begin
            wr(`RGPG_OFF_DLY, 8'(c << 5));
            rise_chk(1, ms_tab[c]);
            wr(`RGPG_OFF_DLY, 8'(c << 2));
            rise_chk(2, ms_tab[c]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(`RGPG_OFF_DLY, 8'(c));
            rise_chk(0, ms_tab[c]);
        end
        $display("test delay done, errors %0d", error_cnt);
    endtask
    task automatic t_edit();
        wr(`RGPG_OFF_DLY, 8'h60);  // output two 15 ms
        rail(1, 1'b1);
        repeat (20) @(posedge i_clk);
        wr(`RGPG_OFF_DLY, 8'h00);  // edit lands mid-interval
        wait_pg(1, 1'b1, n);
        chk_rng("pg_edit", 54, 70, n + 22);
        rail(1, 1'b0);
        wait_pg(1, 1'b0, m);
        wr(`RGPG_OFF_DLY, 8'h60);
        rail(1, 1'b1);
        repeat (30) @(posedge i_clk);
        rail(1, 1'b0);  // drop before the delay ends
        // wait past the point where an unbroken count would have ended
        repeat (40) @(posedge i_clk);
        #1 chk8("pg_mid", 8'h00, {7'h00, o_power_good[1]});
        rail(1, 1'b1);
        wait_pg(1, 1'b1, n);
        chk_rng("pg_restart", 54, 70, n);
        rail(1, 1'b0);
        wait_pg(1, 1'b0, m);
        $display("test edit done, errors %0d", error_cnt);
    endtask
    task automatic t_nopg();
        @(posedge i_clk);
        i_out_is_pg <= 3'b011;  // output four as level shifter
        wr(`RGPG_OFF_DLY, 8'h1C);
        rail(2, 1'b1);
        wait_pg(2, 1'b1, n);
        chk_rng("pg_shift", 1, 4, n);
        rail(2, 1'b0);
        wait_pg(2, 1'b0, m);
        chk_rng("pg_shift_drop", 1, 4, m);
        @(posedge i_clk);
        i_out_is_pg <= 3'b111;
        $display("test nopg done, errors %0d", error_cnt);
    endtask
    // ****************************************************************
    // verdict, watchdog and main sequence
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);  // well over the ~2800 needed
        error_cnt++;
        $display("[ERR] watchdog expected finish seen hang");
        conclude();
    end
    initial begin
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_addr = 8'h00;
        i_wr_data = 8'h00;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        i_rail_ctrl_on = 3'b000;
        i_conv_forced_on = 3'b000;
        i_rails_in_reg = 3'b000;
        i_out_is_pg = 3'b111;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_mode();
        t_delay();
        t_edit();
        t_nopg();
        conclude();
    end
endmodule  // testbench
`default_nettype wire
